// ==== core/ncs_dev.sv ====
/*
  coprocessor end: option word, condition codes, exception flags,
  error summary / fault, saved instruction and operand pointers.
  assumes: host keeps a request stable until req_ready; arithmetic
  datapath outside reports raised exceptions, compare order and class.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
// Behaviour
// - compare sets cond3 cond2 cond0 per order
// - examine encodes class, cond1 holds sign
// - option bits 5..0 mask six exceptions
// - infinity bit writable, affine always used
// - infinity bit cleared by reset and initialise
// - rounding mode from option bits 11..10
// - rounding only on stores, transcendental, arithmetic
// - precision from option bits 9..8
// - precision only for add sub mul div sqrt
// - record instruction address, operand address, opcode
// - operand address undefined without memory operand
// - of control ops, only environment/state transfers move pointers
// - cpu raises vector 7 on emulate/task switch
// - vector 9 not restartable, reinitialise no-wait
// - vector 13 leaves pointers of previous instruction
// - vector 16 only from escape or wait
// - no-wait control forms never raise vector 16
// - restart allowed after pending exception cleared
// - unmasked exception sets flag, summary, fault
// - reset/initialise load option word 037F
`timescale 1ns/1ps
`include "ncs_params.svh"
module ncs_dev (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  ncs_if.dev LNK,
  output logic [1:0] O_ROUND_SEL,
  output logic O_ROUND_EN,
  output logic [1:0] O_PREC_SEL,
  output logic O_PREC_EN,
  output logic O_AFFINE,
  output logic [5:0] O_MASK,
  output logic [5:0] O_FLAGS,
  output logic [3:0] O_COND,
  output logic O_ERROR_SUMMARY
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  // {cond3, cond2, cond0} of a compare
  function automatic logic [2:0] cmp_code(input ncs_pkg::ncs_cmp_e c);
    case (c)
      ncs_pkg::CMP_GT: cmp_code = 3'h0;
      ncs_pkg::CMP_LT: cmp_code = 3'h1;
      ncs_pkg::CMP_EQ: cmp_code = 3'h4;
      default: cmp_code = 3'h7;
    endcase
  endfunction : cmp_code

  function automatic logic [15:0] sts_word(input logic [5:0] f, input logic [3:0] c, input logic e);
    logic [15:0] w;
    w = 16'h0000;
    w[5:0] = f;
    w[`NCS_STS_ES_BIT] = e;
    w[`NCS_STS_C0_BIT] = c[0];
    w[`NCS_STS_C1_BIT] = c[1];
    w[`NCS_STS_C2_BIT] = c[2];
    w[`NCS_STS_C3_BIT] = c[3];
    w[`NCS_STS_B_BIT] = e;
    sts_word = w;
  endfunction : sts_word

  function automatic logic is_numeric(input ncs_pkg::ncs_op_e op);
    is_numeric = (op == ncs_pkg::OP_COMP) || (op == ncs_pkg::OP_EXAM) || (op == ncs_pkg::OP_ARITH) ||
      (op == ncs_pkg::OP_STORE) || (op == ncs_pkg::OP_TRANS) || (op == ncs_pkg::OP_NORND);
  endfunction : is_numeric

  // ----------------------------------------
  // state
  // ----------------------------------------
  ncs_pkg::ncs_dev_st_e st_r;
  logic [15:0] opt_r, opt_nxt;
  logic [5:0] flags_r, flags_nxt;
  logic [3:0] cond_r;
  logic es_r;
  logic [31:0] ip_r, dp_r;
  logic [10:0] opc_r;
  logic rnd_en_r, prec_en_r, affine_r;
  logic ready_r, rsp_valid_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic take;
  logic is_init, is_clex, is_ld, is_st;

  logic [2:0] cmp_c;
  assign take = LNK.req_valid && ready_r;
  assign cmp_c = cmp_code(LNK.req_cmp);
  assign is_init = (LNK.req_op == ncs_pkg::OP_INIT) || (LNK.req_op == ncs_pkg::OP_NINIT);
  assign is_clex = (LNK.req_op == ncs_pkg::OP_CLEX) || (LNK.req_op == ncs_pkg::OP_NCLEX);
  assign is_ld = (LNK.req_op == ncs_pkg::OP_LDENV) || (LNK.req_op == ncs_pkg::OP_RSTOR);
  assign is_st = (LNK.req_op == ncs_pkg::OP_STENV) || (LNK.req_op == ncs_pkg::OP_NSTENV) ||
    (LNK.req_op == ncs_pkg::OP_SAVE) || (LNK.req_op == ncs_pkg::OP_NSAVE);

  // ----------------------------------------
  // handshake: one request, answer next cycle
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      st_r <= ncs_pkg::DS_IDLE;
      ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
    end else begin
      case (st_r)
        ncs_pkg::DS_IDLE: begin
          rsp_valid_r <= 1'b0;
          if (take) begin
            st_r <= ncs_pkg::DS_RESP;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b1;
          end
        end
        ncs_pkg::DS_RESP: begin
          st_r <= ncs_pkg::DS_IDLE;
          ready_r <= 1'b1;
          rsp_valid_r <= 1'b0;
        end
        default: begin
          st_r <= ncs_pkg::DS_IDLE;
          ready_r <= 1'b1;
          rsp_valid_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // option word
  // ----------------------------------------
  always_comb begin
    opt_nxt = opt_r;
    if (take && is_init)
      opt_nxt = `NCS_OPT_RESET;
    else if (take && (LNK.req_op == ncs_pkg::OP_LDCW))
      opt_nxt = LNK.req_wdata;
    else if (take && is_ld && (LNK.req_beat == `NCS_BEAT_OPT))
      opt_nxt = LNK.req_wdata;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST)
      opt_r <= `NCS_OPT_RESET;
    else
      opt_r <= opt_nxt;
  end

  // ----------------------------------------
  // exception flags and error summary
  // ----------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (take && (is_init || is_clex))
      flags_nxt = 6'h00;
    else if (take && is_ld && (LNK.req_beat == `NCS_BEAT_STS))
      flags_nxt = LNK.req_wdata[5:0];
    else if (take && is_numeric(LNK.req_op))
      flags_nxt = flags_r | LNK.req_exc;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      flags_r <= 6'h00;
      es_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      // summary follows unmasked flags, also after an image load
      es_r <= |(flags_nxt & ~opt_nxt[`NCS_OPT_MASK_HI:0]);
    end
  end

  // ----------------------------------------
  // condition codes {cond3, cond2, cond1, cond0}
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      cond_r <= 4'h0;
    end else if (take) begin
      if (is_init) begin
        cond_r <= 4'h0;
      end else if (LNK.req_op == ncs_pkg::OP_COMP) begin
        cond_r <= {cmp_c[2:1], 1'b0, cmp_c[0]};
      end else if (LNK.req_op == ncs_pkg::OP_EXAM) begin
        cond_r <= {LNK.req_class[2:1], LNK.req_sign, LNK.req_class[0]};
      end else if (is_ld && (LNK.req_beat == `NCS_BEAT_STS)) begin
        cond_r <= {LNK.req_wdata[`NCS_STS_C3_BIT], LNK.req_wdata[`NCS_STS_C2_BIT],
          LNK.req_wdata[`NCS_STS_C1_BIT], LNK.req_wdata[`NCS_STS_C0_BIT]};
      end
    end
  end

  // ----------------------------------------
  // saved pointers
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ip_r <= 32'h0000_0000;
      dp_r <= 32'h0000_0000;
      opc_r <= 11'h000;
    end else if (take && is_numeric(LNK.req_op)) begin
      ip_r <= LNK.req_ip;
      opc_r <= LNK.req_opcode;
      if (LNK.req_has_mem)
        dp_r <= LNK.req_dp;
    end else if (take && is_ld) begin
      // image layout differs in protected and real mode
      case (LNK.req_beat)
        `NCS_BEAT_IPLO: ip_r[15:0] <= LNK.req_wdata;
        `NCS_BEAT_IPHI: begin
          if (LNK.req_prot) begin
            ip_r[31:16] <= LNK.req_wdata;
          end else begin
            ip_r[31:16] <= {12'h000, LNK.req_wdata[15:12]};
            opc_r <= LNK.req_wdata[10:0];
          end
        end
        `NCS_BEAT_DPLO: dp_r[15:0] <= LNK.req_wdata;
        `NCS_BEAT_DPHI: begin
          if (LNK.req_prot)
            dp_r[31:16] <= LNK.req_wdata;
          else
            dp_r[31:16] <= {12'h000, LNK.req_wdata[15:12]};
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // answer data
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 16'h0000;
    case (LNK.req_op)
      ncs_pkg::OP_STCW: rdata_nxt = opt_r;
      ncs_pkg::OP_STSW, ncs_pkg::OP_NSTSW: rdata_nxt = sts_word(flags_r, cond_r, es_r);
      default: begin
        if (is_st) begin
          case (LNK.req_beat)
            `NCS_BEAT_OPT: rdata_nxt = opt_r;
            `NCS_BEAT_STS: rdata_nxt = sts_word(flags_r, cond_r, es_r);
            `NCS_BEAT_IPLO: rdata_nxt = ip_r[15:0];
            `NCS_BEAT_IPHI: rdata_nxt = LNK.req_prot ? ip_r[31:16] : {ip_r[19:16], 1'b0, opc_r};
            `NCS_BEAT_DPLO: rdata_nxt = dp_r[15:0];
            `NCS_BEAT_DPHI: rdata_nxt = LNK.req_prot ? dp_r[31:16] : {dp_r[19:16], 12'h000};
            default: rdata_nxt = 16'h0000;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST)
      rdata_r <= 16'h0000;
    else if (take)
      rdata_r <= rdata_nxt;
  end

  // ----------------------------------------
  // datapath steering of the last numeric op
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rnd_en_r <= 1'b0;
      prec_en_r <= 1'b0;
    end else if (take && is_numeric(LNK.req_op)) begin
      rnd_en_r <= (LNK.req_op == ncs_pkg::OP_ARITH) || (LNK.req_op == ncs_pkg::OP_STORE) ||
        (LNK.req_op == ncs_pkg::OP_TRANS);
      prec_en_r <= (LNK.req_op == ncs_pkg::OP_ARITH);
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    affine_r <= 1'b1;
  end

  assign LNK.req_ready = ready_r;
  assign LNK.rsp_valid = rsp_valid_r;
  assign LNK.rsp_rdata = rdata_r;
  assign LNK.fault = es_r;
  assign O_ROUND_SEL = opt_r[`NCS_OPT_RND_LO +: 2];
  assign O_ROUND_EN = rnd_en_r;
  assign O_PREC_SEL = opt_r[`NCS_OPT_PREC_LO +: 2];
  assign O_PREC_EN = prec_en_r;
  // affine ordering regardless of the infinity bit
  assign O_AFFINE = affine_r;
  assign O_MASK = opt_r[`NCS_OPT_MASK_HI:0];
  assign O_FLAGS = flags_r;
  assign O_COND = cond_r;
  assign O_ERROR_SUMMARY = es_r;
endmodule : ncs_dev

// ==== core/ncs_host.sv ====
/*
  cpu end: apb register front, vector 7/9/13/16 decisions, issues
  requests on the link and collects answers.
  assumes: apb master per the bus rules; device answers on the link.
*/
`timescale 1ns/1ps
`include "ncs_params.svh"
module ncs_host (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  ncs_if.host LNK,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_VEC_VALID,
  output logic [7:0] O_VECTOR
);
  function automatic logic is_nowait(input ncs_pkg::ncs_op_e op);
    is_nowait = (op == ncs_pkg::OP_NINIT) || (op == ncs_pkg::OP_NCLEX) || (op == ncs_pkg::OP_NSTSW) ||
      (op == ncs_pkg::OP_NSTENV) || (op == ncs_pkg::OP_NSAVE);
  endfunction : is_nowait

  // ----------------------------------------
  // registers
  // ----------------------------------------
  ncs_pkg::ncs_host_st_e st_r;
  logic [31:0] cmd_r, wd_r, ip_r, dp_r;
  logic [10:0] opc_r;
  logic emulate_flag_r, task_switched_flag_r;
  logic pready_r, pslverr_r, vec_valid_r, valid_r;
  logic [31:0] prdata_r;
  logic [7:0] vec_r;
  logic [15:0] rdata_r;
  logic acc, wr, start, busy;
  ncs_pkg::ncs_op_e op;

  assign op = ncs_pkg::ncs_op_e'(cmd_r[4:0]);
  assign busy = (st_r != ncs_pkg::HS_IDLE);
  assign acc = I_PSEL && I_PENABLE && pready_r;
  assign wr = acc && I_PWRITE;
  assign start = wr && (I_PADDR == `NCS_REG_CMD) && !busy;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= I_PSEL && !I_PENABLE && !pready_r;
      pslverr_r <= 1'b0;
      if (I_PSEL && !I_PENABLE) begin
        case (I_PADDR)
          `NCS_REG_CMD: prdata_r <= cmd_r;
          `NCS_REG_WDATA: prdata_r <= wd_r;
          `NCS_REG_IP: prdata_r <= ip_r;
          `NCS_REG_DP: prdata_r <= dp_r;
          `NCS_REG_OPCODE: prdata_r <= {21'h000000, opc_r};
          `NCS_REG_CR0: prdata_r <= {30'h00000000, task_switched_flag_r, emulate_flag_r};
          `NCS_REG_STAT: prdata_r <= {rdata_r, vec_r, 5'h00, LNK.fault, vec_valid_r, busy};
          default: begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b1;
          end
        endcase
        if (I_PWRITE && (I_PADDR == `NCS_REG_CMD) && busy)
          pslverr_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      cmd_r <= 32'h0000_0000;
      wd_r <= 32'h0000_0000;
      ip_r <= 32'h0000_0000;
      dp_r <= 32'h0000_0000;
      opc_r <= 11'h000;
      emulate_flag_r <= 1'b0;
      task_switched_flag_r <= 1'b0;
    end else if (wr) begin
      case (I_PADDR)
        `NCS_REG_CMD: if (!busy) cmd_r <= I_PWDATA;
        `NCS_REG_WDATA: wd_r <= I_PWDATA;
        `NCS_REG_IP: ip_r <= I_PWDATA;
        `NCS_REG_DP: dp_r <= I_PWDATA;
        `NCS_REG_OPCODE: opc_r <= I_PWDATA[10:0];
        `NCS_REG_CR0: begin
          emulate_flag_r <= I_PWDATA[0];
          task_switched_flag_r <= I_PWDATA[1];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // issue and vector decision
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      st_r <= ncs_pkg::HS_IDLE;
      valid_r <= 1'b0;
      vec_valid_r <= 1'b0;
      vec_r <= 8'h00;
      rdata_r <= 16'h0000;
    end else begin
      case (st_r)
        ncs_pkg::HS_IDLE: begin
          if (start) begin
            vec_valid_r <= 1'b0;
            if ((I_PWDATA[4:0] != 5'h00 && emulate_flag_r) || task_switched_flag_r) begin
              vec_valid_r <= 1'b1;
              vec_r <= `NCS_VEC_NOTAVAIL;
            end else if (wd_r[25]) begin
              vec_valid_r <= 1'b1;
              vec_r <= `NCS_VEC_GPROT;
            end else if (wd_r[24]) begin
              vec_valid_r <= 1'b1;
              vec_r <= `NCS_VEC_OVERRUN;
            end else if (LNK.fault && !is_nowait(ncs_pkg::ncs_op_e'(I_PWDATA[4:0]))) begin
              vec_valid_r <= 1'b1;
              vec_r <= `NCS_VEC_NUMERR;
            end else if (I_PWDATA[4:0] != 5'h00) begin
              st_r <= ncs_pkg::HS_REQ;
              valid_r <= 1'b1;
            end
          end
        end
        ncs_pkg::HS_REQ: begin
          if (LNK.req_ready) begin
            valid_r <= 1'b0;
            st_r <= ncs_pkg::HS_WAIT;
          end
        end
        ncs_pkg::HS_WAIT: begin
          if (LNK.rsp_valid) begin
            rdata_r <= LNK.rsp_rdata;
            st_r <= ncs_pkg::HS_IDLE;
          end
        end
        default: begin
          st_r <= ncs_pkg::HS_IDLE;
          valid_r <= 1'b0;
        end
      endcase
    end
  end

  assign LNK.req_valid = valid_r;
  assign LNK.req_op = op;
  assign LNK.req_beat = cmd_r[10:8];
  assign LNK.req_has_mem = cmd_r[12];
  assign LNK.req_prot = cmd_r[13];
  assign LNK.req_cmp = ncs_pkg::ncs_cmp_e'(cmd_r[17:16]);
  assign LNK.req_class = ncs_pkg::ncs_class_e'(cmd_r[22:20]);
  assign LNK.req_sign = cmd_r[23];
  assign LNK.req_wdata = wd_r[15:0];
  assign LNK.req_exc = wd_r[21:16];
  assign LNK.req_ip = ip_r;
  assign LNK.req_dp = dp_r;
  assign LNK.req_opcode = opc_r;
  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_VEC_VALID = vec_valid_r;
  assign O_VECTOR = vec_r;
endmodule : ncs_host

// ==== core/ncs_if.sv ====
/*
  link between the cpu end (host) and the coprocessor end (dev).
  assumes: both ends share one clock; no clocking block here.
*/
`timescale 1ns/1ps
interface ncs_if;
  logic req_valid;
  logic req_ready;
  ncs_pkg::ncs_op_e req_op;
  logic [2:0] req_beat;
  logic [15:0] req_wdata;
  logic [31:0] req_ip;
  logic [31:0] req_dp;
  logic [10:0] req_opcode;
  logic req_has_mem;
  logic req_prot;
  ncs_pkg::ncs_cmp_e req_cmp;
  ncs_pkg::ncs_class_e req_class;
  logic req_sign;
  logic [5:0] req_exc;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic fault;
  modport host (
    output req_valid, req_op, req_beat, req_wdata, req_ip, req_dp, req_opcode,
    output req_has_mem, req_prot, req_cmp, req_class, req_sign, req_exc,
    input req_ready, rsp_valid, rsp_rdata, fault
  );
  modport dev (
    input req_valid, req_op, req_beat, req_wdata, req_ip, req_dp, req_opcode,
    input req_has_mem, req_prot, req_cmp, req_class, req_sign, req_exc,
    output req_ready, rsp_valid, rsp_rdata, fault
  );
endinterface : ncs_if

// ==== core/ncs_params.svh ====
/*
  constants of the numeric control/status block: option word fields,
  reset values, cpu vectors, host register offsets.
  assumes: included by bare name, definitions only.
*/
`ifndef NCS_PARAMS_SVH
`define NCS_PARAMS_SVH
// ----------------------------------------
// option word
// ----------------------------------------
`define NCS_OPT_RESET 16'h037F
`define NCS_OPT_MASK_HI 5
`define NCS_OPT_PREC_LO 8
`define NCS_OPT_RND_LO 10
`define NCS_OPT_INF_BIT 12
// ----------------------------------------
// status word image
// ----------------------------------------
`define NCS_STS_ES_BIT 7
`define NCS_STS_C0_BIT 8
`define NCS_STS_C1_BIT 9
`define NCS_STS_C2_BIT 10
`define NCS_STS_C3_BIT 14
`define NCS_STS_B_BIT 15
// ----------------------------------------
// environment image beats
// ----------------------------------------
`define NCS_BEAT_OPT 3'h0
`define NCS_BEAT_STS 3'h1
`define NCS_BEAT_IPLO 3'h2
`define NCS_BEAT_IPHI 3'h3
`define NCS_BEAT_DPLO 3'h4
`define NCS_BEAT_DPHI 3'h5
// ----------------------------------------
// cpu vectors
// ----------------------------------------
`define NCS_VEC_NOTAVAIL 8'h07
`define NCS_VEC_OVERRUN 8'h09
`define NCS_VEC_GPROT 8'h0D
`define NCS_VEC_NUMERR 8'h10
// ----------------------------------------
// host apb registers
// ----------------------------------------
`define NCS_REG_CMD 8'h00
`define NCS_REG_WDATA 8'h04
`define NCS_REG_IP 8'h08
`define NCS_REG_DP 8'h0C
`define NCS_REG_OPCODE 8'h10
`define NCS_REG_CR0 8'h14
`define NCS_REG_STAT 8'h18
`endif

// ==== core/ncs_pkg.sv ====
/*
  types of the numeric control/status block.
  assumes: nothing beyond the compiler.
*/
package ncs_pkg;
  typedef enum logic [4:0] {
    OP_WAIT = 5'h00, OP_INIT = 5'h01, OP_NINIT = 5'h02, OP_CLEX = 5'h03,
    OP_NCLEX = 5'h04, OP_LDCW = 5'h05, OP_STCW = 5'h06, OP_STSW = 5'h07,
    OP_NSTSW = 5'h08, OP_COMP = 5'h09, OP_EXAM = 5'h0A, OP_ARITH = 5'h0B,
    OP_STORE = 5'h0C, OP_TRANS = 5'h0D, OP_NORND = 5'h0E, OP_STENV = 5'h0F,
    OP_NSTENV = 5'h10, OP_SAVE = 5'h11, OP_NSAVE = 5'h12, OP_LDENV = 5'h13,
    OP_RSTOR = 5'h14
  } ncs_op_e;
  typedef enum logic [1:0] {
    CMP_GT = 2'h0, CMP_LT = 2'h1, CMP_EQ = 2'h2, CMP_UN = 2'h3
  } ncs_cmp_e;
  typedef enum logic [2:0] {
    CL_UNSUP = 3'h0, CL_NAN = 3'h1, CL_NORMAL = 3'h2, CL_INF = 3'h3,
    CL_ZERO = 3'h4, CL_EMPTY = 3'h5, CL_DENORM = 3'h6
  } ncs_class_e;
  typedef enum logic [0:0] {DS_IDLE = 1'b0, DS_RESP = 1'b1} ncs_dev_st_e;
  typedef enum logic [1:0] {HS_IDLE = 2'h0, HS_REQ = 2'h1, HS_WAIT = 2'h2} ncs_host_st_e;
endpackage : ncs_pkg

// ==== test/ncs_checker.sv ====
/*
  link checker for the numeric control/status block.
  assumes: instantiated in the bench beside ncs_if; one clock, sync reset.
*/
`timescale 1ns/1ps
module ncs_checker (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic req_valid,
  input wire logic req_ready,
  input ncs_pkg::ncs_op_e req_op,
  input wire logic [2:0] req_beat,
  input wire logic [15:0] req_wdata,
  input wire logic [5:0] req_exc,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic fault
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  logic take;
  logic unmasked;
  logic [15:0] opt_r;
  ncs_pkg::ncs_op_e last_r;
  assign take = req_valid && req_ready;
  assign unmasked = |(req_exc & ~opt_r[5:0]);
  // ----------------------------------------
  // shadow of the option word
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST)
      opt_r <= 16'h037F;
    else if (take && (req_op == ncs_pkg::OP_LDCW ||
             (req_op inside {ncs_pkg::OP_LDENV, ncs_pkg::OP_RSTOR} && req_beat == 3'h0)))
      opt_r <= req_wdata;
    else if (take && req_op inside {ncs_pkg::OP_INIT, ncs_pkg::OP_NINIT})
      opt_r <= 16'h037F;
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST)
      last_r <= ncs_pkg::OP_WAIT;
    else if (take)
      last_r <= req_op;
  end
  // ----------------------------------------
  // link steps
  // ----------------------------------------
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    rsp_valid && !req_ready ##1 !rsp_valid && req_ready;
  endsequence
  a_take_answer: assert property (s_take |=> s_answer)
    else $error("answer not one cycle after take");
  a_rsp_cause: assert property (rsp_valid |-> $past(take))
    else $error("answer without a take");
  a_one_outstanding: assert property (s_take |=> !req_valid)
    else $error("request kept after take");
  a_opt_read: assert property (rsp_valid && last_r == ncs_pkg::OP_STCW |->
    (rsp_rdata & 16'h1F3F) == (opt_r & 16'h1F3F))
    else $error("option word readback wrong");
  a_fault_raise: assert property (take && req_op == ncs_pkg::OP_ARITH && unmasked |-> ##[1:2] fault)
    else $error("unmasked exception without fault");
  a_masked_quiet: assert property (take && req_op == ncs_pkg::OP_ARITH && !unmasked && !fault |=> !fault)
    else $error("masked exception raised fault");
  a_fault_clear: assert property (take && req_op inside {ncs_pkg::OP_NCLEX, ncs_pkg::OP_NINIT} |=> !fault)
    else $error("fault kept after clear");
  a_fault_quiet: assert property (!rsp_valid |-> $stable(fault))
    else $error("fault moved outside an answer");
endmodule : ncs_checker

// ==== test/testbench.sv ====
/*
  self-checking bench: host and coprocessor ends joined by ncs_if.
  assumes: core/ compiled first; apb driven from here.
*/
`timescale 1ns/1ps
`include "ncs_params.svh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, stat, w, ip, dp;
  logic [63:0] pv;
  logic pready, pslverr, vec_valid, err, round_en, prec_en, affine, es;
  logic [7:0] vector;
  logic [1:0] round_sel, prec_sel;
  logic [5:0] mask, flags;
  logic [3:0] cond;
  int fails = 0;
  int checked = 0;
  integer seed = 44;
  ncs_pkg::ncs_op_e ol [4] = '{ncs_pkg::OP_ARITH, ncs_pkg::OP_STORE, ncs_pkg::OP_TRANS, ncs_pkg::OP_NORND};
  ncs_pkg::ncs_op_e nw [4] = '{ncs_pkg::OP_NSTSW, ncs_pkg::OP_NSTENV, ncs_pkg::OP_NSAVE, ncs_pkg::OP_NCLEX};
  ncs_if lnk ();
  ncs_dev ncs_dev_i (.I_SYS_CLK(clk), .I_SRST(srst), .LNK(lnk), .O_ROUND_SEL(round_sel),
    .O_ROUND_EN(round_en), .O_PREC_SEL(prec_sel), .O_PREC_EN(prec_en), .O_AFFINE(affine),
    .O_MASK(mask), .O_FLAGS(flags), .O_COND(cond), .O_ERROR_SUMMARY(es));
  ncs_host ncs_host_i (.I_SYS_CLK(clk), .I_SRST(srst), .LNK(lnk), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_VEC_VALID(vec_valid), .O_VECTOR(vector));
  ncs_checker ncs_checker_i (.I_SYS_CLK(clk), .I_SRST(srst), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_op(lnk.req_op), .req_beat(lnk.req_beat), .req_wdata(lnk.req_wdata),
    .req_exc(lnk.req_exc), .rsp_valid(lnk.rsp_valid), .rsp_rdata(lnk.rsp_rdata), .fault(lnk.fault));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] cmp_exp(input logic [1:0] c);
    return {c[1], c == 2'h3, 1'b0, c[0]};
  endfunction : cmp_exp
  // class codes run in the same order as cond3 cond2 cond0
  function automatic logic [3:0] cls_exp(input logic [2:0] k, input logic s);
    return {k[2], k[1], s, k[0]};
  endfunction : cls_exp
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task op(input logic [4:0] o, input logic [31:0] wd, input logic [31:0] x);
    apb(1'b1, `NCS_REG_WDATA, wd);
    apb(1'b1, `NCS_REG_CMD, x | {27'h0, o});
    do begin
      apb(1'b0, `NCS_REG_STAT, 32'h0);
    end while (rd[0] !== 1'b0);
    stat = rd;
  endtask : op
  task vchk(input logic v, input logic [7:0] n);
    chk("vector", {23'h0, vec_valid, v ? vector : 8'h00}, {23'h0, v, n});
  endtask : vchk
  task img_chk;
    for (int b = 2; b < 6; b++) begin
      op(ncs_pkg::OP_NSTENV, 32'h0, 32'h2000 | (b << 8));
      chk("pointer image", {16'h0, stat[31:16]}, {16'h0, pv[16 * (b - 2) +: 16]});
    end
  endtask : img_chk
  task results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("reset option", {21'h0, round_sel, prec_sel, mask, affine}, {21'h0, 10'h0FF, 1'b1});
    for (int i = 0; i < 9; i++) begin
      w = (i == 8) ? 32'h1000 : $random(seed) & 32'h1F3F;
      op(ncs_pkg::OP_LDCW, w, 32'h0);
      chk("option fields", {22'h0, round_sel, prec_sel, mask}, {22'h0, w[11:8], w[5:0]});
      chk("affine", {31'h0, affine}, 32'h1);
      op(ncs_pkg::OP_STCW, 32'h0, 32'h0);
      chk("infinity bit", {31'h0, stat[28]}, {31'h0, w[12]});
    end
    op(ncs_pkg::OP_NINIT, 32'h0, 32'h0);
    op(ncs_pkg::OP_STCW, 32'h0, 32'h0);
    chk("init option", {16'h0, stat[31:16]}, 32'h037F);
    for (int c = 0; c < 4; c++) begin
      op(ncs_pkg::OP_COMP, 32'h0, c << 16);
      chk("compare cond", {28'h0, cond}, {28'h0, cmp_exp(c[1:0])});
    end
    for (int k = 0; k < 14; k++) begin
      op(ncs_pkg::OP_EXAM, 32'h0, ((k >> 1) << 20) | ((k & 1) << 23));
      chk("class cond", {28'h0, cond}, {28'h0, cls_exp(3'(k >> 1), k[0])});
    end
    for (int i = 0; i < 4; i++) begin
      op(ol[i], $random(seed) & 32'h003F0000, 32'h0);
      chk("round prec enables", {30'h0, round_en, prec_en}, {30'h0, i != 3, i == 0});
    end
    ip = $random(seed);
    dp = $random(seed);
    pv = {dp, ip};
    apb(1'b1, `NCS_REG_IP, ip);
    apb(1'b1, `NCS_REG_DP, dp);
    op(ncs_pkg::OP_ARITH, 32'h0, 32'h3000);
    img_chk();
    apb(1'b1, `NCS_REG_IP, ~ip);
    apb(1'b1, `NCS_REG_DP, ~dp);
    op(ncs_pkg::OP_ARITH, 32'h02000000, 32'h3000);
    vchk(1'b1, `NCS_VEC_GPROT);
    img_chk();
    op(ncs_pkg::OP_ARITH, 32'h01000000, 32'h3000);
    vchk(1'b1, `NCS_VEC_OVERRUN);
    op(ncs_pkg::OP_NINIT, 32'h0, 32'h0);
    op(ncs_pkg::OP_LDCW, 32'h037E, 32'h0);
    op(ncs_pkg::OP_ARITH, 32'h00010000, 32'h0);
    chk("exception report", {24'h0, es, stat[2], flags}, 32'hC1);
    op(ncs_pkg::OP_WAIT, 32'h0, 32'h0);
    vchk(1'b1, `NCS_VEC_NUMERR);
    for (int i = 0; i < 4; i++) begin
      op(nw[i], 32'h0, 32'h0);
      vchk(1'b0, 8'h00);
    end
    chk("cleared summary", {30'h0, es, stat[2]}, 32'h0);
    op(ncs_pkg::OP_WAIT, 32'h0, 32'h0);
    vchk(1'b0, 8'h00);
    apb(1'b1, `NCS_REG_CR0, 32'h1);
    op(ncs_pkg::OP_ARITH, 32'h0, 32'h0);
    vchk(1'b1, `NCS_VEC_NOTAVAIL);
    op(ncs_pkg::OP_WAIT, 32'h0, 32'h0);
    vchk(1'b0, 8'h00);
    apb(1'b1, `NCS_REG_CR0, 32'h2);
    op(ncs_pkg::OP_WAIT, 32'h0, 32'h0);
    vchk(1'b1, `NCS_VEC_NOTAVAIL);
    apb(1'b1, `NCS_REG_CR0, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    results();
  end
endmodule : testbench
